// ===== verilog/flsq_top.sv
// Purpose: Command interpreter, automatic program/erase sequencer and status for the flash array.
// Assumes: Control bits come from logic on CLK_SYS; bus strobes last one cycle each.
// Notes: Summary of operation follows.
// Summary of operation
// - Byte bus; FFh first cycle selects array reads
// - Array mode persists; reads return addressed bytes while ready
// - After 70h reads return the status byte
// - 50h clears both error flags and mirrors
// - 40h then data at address starts program
// - Ready reads 0 while busy, 1 after
// - Program verify failure sets program error only
// - Block 0 refused unless enabled and unlocked
// - Block 1 refused while its lock is set
// - Mode a: start of operation selects status reads
// - 20h then D0h in block starts erase
// - Erase verify failure sets erase error only
// - Sequence errors set both error flags
// - FFh second cycle abandons command, array mode
// - Error flags set refuse program and erase
// - Mode a status reads last until FFh
// - Status bits mirrored to control flags
// - Commands accepted only with rewrite enable set
// - Block01 enable low refuses blocks 0 and 1
`timescale 1ns/10ps
module flsq_top
	import flsq_pkg::*;
#(
	parameter int ERASE_CYCLES = ERASE_CYCLES_DEF
)
(
	input  wire logic              CLK_SYS,
	input  wire logic              RST,
	input  wire logic              CE,
	input  wire logic              BUS_WR,
	input  wire logic              BUS_RD,
	input  wire logic [ADDR_W-1:0] BUS_ADDR,
	input  wire logic [DATA_W-1:0] BUS_WDATA,
	output logic      [DATA_W-1:0] BUS_RDATA,
	output logic                   BUS_RVALID,
	input  wire logic              CPU_REWRITE_ENABLE,
	input  wire logic              BLOCK01_REWRITE_ENABLE,
	input  wire logic              BLOCK0_REWRITE_LOCK,
	input  wire logic              BLOCK1_REWRITE_LOCK,
	input  wire logic              SELF_REWRITE_MODE_B,
	input  wire logic              VERIFY_FAULT,
	output logic                   SEQUENCER_READY_FLAG,
	output logic                   PROGRAM_ERROR_FLAG,
	output logic                   ERASE_ERROR_FLAG,
	output logic                   STATUS_READ_MODE
);
	flsq_state_type    state;
	flsq_state_type    next_state;
	flsq_req_type      req;
	flsq_req_type      target;
	flsq_prot_type     prot;
	logic [CNT_W-1:0]  op_cnt;
	logic [CNT_W-1:0]  op_last;
	logic              op_done;
	logic              ready;
	logic              wr_ok;
	logic              blk_locked;
	logic              target_bad;
	logic              err_any;
	logic              seq_err;
	logic              clr_cmd;
	logic              start_op;
	logic              abandon;
	logic              prog_fail;
	logic              erase_fail;
	logic              prog_err;
	logic              erase_err;
	logic              status_mode;
	logic [DATA_W-1:0] status_byte;
	logic [DATA_W-1:0] prog_merge;
	logic [ADDR_W-1:0] mem_addr;
	logic              mem_we;
	logic [DATA_W-1:0] mem_wdata;
	logic              mem_re;
	logic [DATA_W-1:0] mem_rdata;
	logic              rd_pend;
	logic              rd_stat;

	assign req  = '{addr: BUS_ADDR, data: BUS_WDATA};
	assign prot = '{cpu_rewrite_enable:     CPU_REWRITE_ENABLE,
	                block01_rewrite_enable: BLOCK01_REWRITE_ENABLE,
	                block0_rewrite_lock:    BLOCK0_REWRITE_LOCK,
	                block1_rewrite_lock:    BLOCK1_REWRITE_LOCK};

	assign ready = (state == ST_IDLE) || (state == ST_PROG_ARM) || (state == ST_ERASE_ARM);
	// Writes during an operation are dropped: the array port belongs to the sequencer then
	assign wr_ok = BUS_WR && prot.cpu_rewrite_enable && ready;
	assign err_any = prog_err || erase_err;

	always_comb
	begin
		blk_locked = 1'b0;
		if (req.addr[ADDR_W-1:BLK_SHIFT] == BLK_ZERO)
			blk_locked = !prot.block01_rewrite_enable || prot.block0_rewrite_lock;
		else if (req.addr[ADDR_W-1:BLK_SHIFT] == BLK_ONE)
			blk_locked = !prot.block01_rewrite_enable || prot.block1_rewrite_lock;
	end

	assign target_bad = blk_locked || (req.addr >= USER_TOP);

	assign op_last = (state == ST_ERASE_RUN) ? CNT_W'(ERASE_CYCLES - 1) : CNT_W'(PROG_CYCLES - 1);
	assign op_done = (op_cnt == op_last);

	always_comb
	begin
		next_state = state;
		seq_err    = 1'b0;
		clr_cmd    = 1'b0;
		start_op   = 1'b0;
		abandon    = 1'b0;
		case (state)
			ST_IDLE:
			begin
				if (wr_ok)
				begin
					case (req.data)
						CMD_PROGRAM:      next_state = ST_PROG_ARM;
						CMD_ERASE:        next_state = ST_ERASE_ARM;
						CMD_CLEAR_STATUS: clr_cmd = 1'b1;
						CMD_READ_ARRAY:   abandon = 1'b1;
						CMD_READ_STATUS:  next_state = ST_IDLE;
						default:          seq_err = 1'b1;
					endcase
				end
			end
			ST_PROG_ARM:
			begin
				if (wr_ok)
				begin
					next_state = ST_IDLE;
					if (req.data == CMD_READ_ARRAY)
						abandon = 1'b1;
					else if (target_bad)
						seq_err = 1'b1;
					else if (!err_any)
					begin
						next_state = ST_PROG_LOAD;
						start_op   = 1'b1;
					end
				end
			end
			ST_ERASE_ARM:
			begin
				if (wr_ok)
				begin
					next_state = ST_IDLE;
					if (req.data == CMD_READ_ARRAY)
						abandon = 1'b1;
					else if ((req.data != CMD_ERASE_CONFIRM) || target_bad)
						seq_err = 1'b1;
					else if (!err_any)
					begin
						next_state = ST_ERASE_RUN;
						start_op   = 1'b1;
					end
				end
			end
			ST_PROG_LOAD: next_state = ST_PROG_RUN;
			ST_PROG_RUN, ST_ERASE_RUN: if (op_done) next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
			state <= ST_IDLE;
		else if (CE)
			state <= next_state;
	end

	// The second-cycle address is the one used; both cycles are expected to agree
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
			target <= '0;
		else if (CE && start_op)
			target <= req;
	end

	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
			op_cnt <= '0;
		else if (CE)
		begin
			if (start_op || (state == ST_PROG_LOAD))
				op_cnt <= '0;
			else if ((state == ST_PROG_RUN) || (state == ST_ERASE_RUN))
				op_cnt <= op_cnt + CNT_W'(1);
		end
	end

	// Flash cells only clear bits, so a program that tries to raise a bit fails verify
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
			prog_merge <= '0;
		else if (CE && (state == ST_PROG_RUN) && (op_cnt == '0))
			prog_merge <= mem_rdata & target.data;
	end

	assign prog_fail  = (state == ST_PROG_RUN) && op_done &&
	                    ((prog_merge != target.data) || VERIFY_FAULT);
	assign erase_fail = (state == ST_ERASE_RUN) && op_done && VERIFY_FAULT;

	// A set in the same cycle as a clear wins
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			prog_err  <= RST_PROG_ERR;
			erase_err <= RST_ERASE_ERR;
		end
		else if (CE)
		begin
			prog_err  <= (prog_err && !clr_cmd) || seq_err || prog_fail;
			erase_err <= (erase_err && !clr_cmd) || seq_err || erase_fail;
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
			status_mode <= RST_STATUS_MODE;
		else if (CE)
		begin
			if (abandon)
				status_mode <= 1'b0;
			else if ((state == ST_IDLE) && wr_ok && (req.data == CMD_READ_STATUS))
				status_mode <= 1'b1;
			else if (start_op && !SELF_REWRITE_MODE_B)
				status_mode <= 1'b1;
		end
	end

	always_comb
	begin
		status_byte               = '0;
		status_byte[SB_READY]     = ready;
		status_byte[SB_ERASE_ERR] = erase_err;
		status_byte[SB_PROG_ERR]  = prog_err;
	end

	always_comb
	begin
		mem_addr  = req.addr;
		mem_we    = 1'b0;
		mem_wdata = ERASED_BYTE;
		mem_re    = BUS_RD && ready;
		case (state)
			ST_PROG_LOAD:
			begin
				mem_addr = target.addr;
				mem_re   = 1'b1;
			end
			ST_PROG_RUN:
			begin
				mem_addr  = target.addr;
				mem_we    = (op_cnt == '0);
				mem_wdata = mem_rdata & target.data;
				mem_re    = 1'b0;
			end
			ST_ERASE_RUN:
			begin
				mem_addr  = {target.addr[ADDR_W-1:BLK_SHIFT], op_cnt[BLK_SHIFT-1:0]};
				mem_we    = (op_cnt < CNT_W'(BLK_SIZE));
				mem_re    = 1'b0;
			end
			default: mem_re = BUS_RD && ready;
		endcase
	end

	flsq_array u_array
	(
		.clk   (CLK_SYS),
		.ce    (CE),
		.addr  (mem_addr),
		.we    (mem_we),
		.wdata (mem_wdata),
		.re    (mem_re),
		.rdata (mem_rdata)
	);

	// Reads during an operation cannot reach the array, so they see the status byte
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			rd_pend    <= 1'b0;
			rd_stat    <= 1'b0;
			BUS_RDATA  <= '0;
			BUS_RVALID <= 1'b0;
		end
		else if (CE)
		begin
			rd_pend    <= BUS_RD;
			rd_stat    <= status_mode || !ready;
			BUS_RVALID <= rd_pend;
			if (rd_pend)
			begin
				BUS_RDATA <= rd_stat ? status_byte : mem_rdata;
			end
		end
	end

	assign SEQUENCER_READY_FLAG = ready;
	assign PROGRAM_ERROR_FLAG   = prog_err;
	assign ERASE_ERROR_FLAG     = erase_err;
	assign STATUS_READ_MODE     = status_mode;

	a_busy_not_ready: assert property (@(posedge CLK_SYS) disable iff (RST)
		((state == ST_PROG_RUN) || (state == ST_ERASE_RUN)) |-> !SEQUENCER_READY_FLAG && !status_byte[SB_READY])
		else $error("ready shown during an operation");
	a_ready_on_done: assert property (@(posedge CLK_SYS) disable iff (RST || !CE)
		((state == ST_PROG_RUN) && op_done) |=> SEQUENCER_READY_FLAG)
		else $error("ready not restored after program");
	a_locked_refused: assert property (@(posedge CLK_SYS) disable iff (RST || !CE)
		((state == ST_PROG_ARM) && wr_ok && blk_locked && (req.data != CMD_READ_ARRAY))
		|=> (state == ST_IDLE) && PROGRAM_ERROR_FLAG && ERASE_ERROR_FLAG)
		else $error("program into locked block not refused");
	a_bad_confirm: assert property (@(posedge CLK_SYS) disable iff (RST || !CE)
		((state == ST_ERASE_ARM) && wr_ok && (req.data != CMD_ERASE_CONFIRM) && (req.data != CMD_READ_ARRAY))
		|=> PROGRAM_ERROR_FLAG && ERASE_ERROR_FLAG && SEQUENCER_READY_FLAG)
		else $error("bad erase confirm not flagged");
	a_clear_flags: assert property (@(posedge CLK_SYS) disable iff (RST || !CE)
		clr_cmd |=> !PROGRAM_ERROR_FLAG && !ERASE_ERROR_FLAG)
		else $error("clear status left a flag set");
	a_status_read: assert property (@(posedge CLK_SYS) disable iff (RST || !CE)
		(BUS_RD && status_mode) |-> ##2 BUS_RVALID && (BUS_RDATA == $past(status_byte)))
		else $error("status read returned wrong byte");
	a_mode_a_status: assert property (@(posedge CLK_SYS) disable iff (RST || !CE)
		(start_op && !SELF_REWRITE_MODE_B) |=> STATUS_READ_MODE ##1 !SEQUENCER_READY_FLAG)
		else $error("mode a start did not select status reads");
	a_abandon_cmd: assert property (@(posedge CLK_SYS) disable iff (RST || !CE)
		(((state == ST_PROG_ARM) || (state == ST_ERASE_ARM)) && wr_ok && (req.data == CMD_READ_ARRAY))
		|=> (state == ST_IDLE) && !STATUS_READ_MODE && $stable(PROGRAM_ERROR_FLAG))
		else $error("FFh second cycle not abandoned");
	a_err_refuse: assert property (@(posedge CLK_SYS) disable iff (RST || !CE)
		(err_any && ((state == ST_PROG_ARM) || (state == ST_ERASE_ARM)) && wr_ok) |=> ready && (state == ST_IDLE))
		else $error("operation started while an error flag is set");
	a_prog_err_only: assert property (@(posedge CLK_SYS) disable iff (RST || !CE)
		(prog_fail && !erase_err) |=> PROGRAM_ERROR_FLAG && !ERASE_ERROR_FLAG)
		else $error("program failure flags wrong");
	a_unused_zero: assert property (@(posedge CLK_SYS) disable iff (RST)
		(status_byte[3:0] == 4'h0) && !status_byte[6])
		else $error("unused status bits not zero");
endmodule

// ===== include/flsq_pkg.sv
// Purpose: Shared constants and types for the flash command sequencer.
// Assumes: 20 MHz system clock, byte-wide command bus, 4 KiB array in 1 KiB blocks.
// Notes: Operation times are nominal figures that stand in for the array's electrical behaviour.
package flsq_pkg;
	localparam int ADDR_W     = 12;
	localparam int DATA_W     = 8;
	localparam int BLK_SHIFT  = 10;
	localparam int BLK_SIZE   = 1024;
	localparam int BLK_W      = ADDR_W - BLK_SHIFT;
	localparam int CNT_W      = 24;
	localparam logic [ADDR_W-1:0] USER_TOP = 12'hC00;
	localparam logic [BLK_W-1:0]  BLK_ZERO = 2'h0;
	localparam logic [BLK_W-1:0]  BLK_ONE  = 2'h1;

	localparam logic [DATA_W-1:0] CMD_READ_ARRAY    = 8'hFF;
	localparam logic [DATA_W-1:0] CMD_READ_STATUS   = 8'h70;
	localparam logic [DATA_W-1:0] CMD_CLEAR_STATUS  = 8'h50;
	localparam logic [DATA_W-1:0] CMD_PROGRAM       = 8'h40;
	localparam logic [DATA_W-1:0] CMD_ERASE         = 8'h20;
	localparam logic [DATA_W-1:0] CMD_ERASE_CONFIRM = 8'hD0;
	localparam logic [DATA_W-1:0] ERASED_BYTE       = 8'hFF;

	localparam int SB_READY     = 7;
	localparam int SB_ERASE_ERR = 5;
	localparam int SB_PROG_ERR  = 4;

	localparam logic RST_PROG_ERR    = 1'b0;
	localparam logic RST_ERASE_ERR   = 1'b0;
	localparam logic RST_STATUS_MODE = 1'b0;

	localparam int CLK_MHZ       = 20;
	localparam int PROG_TIME_US  = 50;
	localparam int PROG_CYCLES   = PROG_TIME_US * CLK_MHZ;
	localparam int ERASE_TIME_MS = 400;
	localparam int ERASE_CYCLES_DEF = ERASE_TIME_MS * 1000 * CLK_MHZ;

	typedef enum logic [5:0] {
		ST_IDLE      = 6'b000001,
		ST_PROG_ARM  = 6'b000010,
		ST_ERASE_ARM = 6'b000100,
		ST_PROG_LOAD = 6'b001000,
		ST_PROG_RUN  = 6'b010000,
		ST_ERASE_RUN = 6'b100000
	} flsq_state_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} flsq_req_type;

	typedef struct packed {
		logic cpu_rewrite_enable;
		logic block01_rewrite_enable;
		logic block0_rewrite_lock;
		logic block1_rewrite_lock;
	} flsq_prot_type;
endpackage

// ===== verilog/flsq_array.sv
// Purpose: Byte-wide flash array storage with one shared read/write port.
// Assumes: Read data appear one clock after the read strobe and hold until the next read.
// Notes: Contents are undefined after power-up until a block is erased.
`timescale 1ns/10ps
module flsq_array
	import flsq_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              ce,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic              we,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic              re,
	output logic      [DATA_W-1:0] rdata
);
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

	always_ff @(posedge clk)
	begin
		if (ce && we)
		begin
			mem[addr] <= wdata;
		end
	end

	always_ff @(posedge clk)
	begin
		if (ce && re)
		begin
			rdata <= mem[addr];
		end
	end
endmodule

// ===== tb/flsq_cpu_model.sv
// Purpose: CPU-side model issuing byte-wide command and read cycles.
// Assumes: One strobe per call, launched just after a rising edge.
// Notes: Released address and data are inverted so a stale value never passes as current.
`timescale 1ns/10ps
module flsq_cpu_model
	import flsq_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              mode_b,
	output logic                   bus_wr,
	output logic                   bus_rd,
	output logic      [ADDR_W-1:0] bus_addr,
	output logic      [DATA_W-1:0] bus_wdata
);
	initial
	begin
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		bus_addr = '0;
		bus_wdata = '0;
	end
	task automatic cyc(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		bus_wr <= w;
		bus_rd <= ~w;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge clk);
		bus_wr <= 1'b0;
		bus_rd <= 1'b0;
		bus_addr <= ~a;
		bus_wdata <= ~d;
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		// Code runs from the array in mode b, so status reads are never asked for there
		if (mode_b && d === CMD_READ_STATUS)
			return;
		cyc(1'b1, a, d);
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a);
		cyc(1'b0, a, bus_wdata);
	endtask
	// The rewrite control code is taken to live outside the array
	task automatic prog(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		wr(a, CMD_PROGRAM);
		wr(a, d);
	endtask
	task automatic erase(input logic [ADDR_W-1:0] a);
		wr(a, CMD_ERASE);
		wr(a, CMD_ERASE_CONFIRM);
	endtask
endmodule

// ===== tb/tb_top.sv
// Purpose: Self-checking bench for the flash command sequencer.
// Assumes: Short erase count; reads answered two cycles after their strobe.
// Notes: Expected read data are queued by the driver and matched by a monitor.
`timescale 1ns/10ps
module tb_top
	import flsq_pkg::*;
;
	localparam int ERASE_N = 1100;
	localparam int LIMIT   = 20000;
	logic              clk_sys, rst, ce, cpu_rew, b01_en, lock0, lock1, mode_b, vfault;
	logic              bus_wr, bus_rd, rvalid, ready, perr, eerr, srm;
	logic [ADDR_W-1:0] bus_addr, a;
	logic [DATA_W-1:0] bus_wdata, rdata, d;
	logic [DATA_W-1:0] exp_q[$];
	logic [14:0]       prot_tab[5] = '{15'h0010, 15'h6020, 15'h5410, 15'h0420, 15'h4C05};
	int                err_count = 0;
	int                checked = 0;
	int                cycles = 0;
	int                n;
	flsq_top #(.ERASE_CYCLES(ERASE_N)) flsq_top_inst (
		.CLK_SYS(clk_sys), .RST(rst), .CE(ce), .BUS_WR(bus_wr), .BUS_RD(bus_rd),
		.BUS_ADDR(bus_addr), .BUS_WDATA(bus_wdata), .BUS_RDATA(rdata), .BUS_RVALID(rvalid),
		.CPU_REWRITE_ENABLE(cpu_rew), .BLOCK01_REWRITE_ENABLE(b01_en), .BLOCK0_REWRITE_LOCK(lock0),
		.BLOCK1_REWRITE_LOCK(lock1), .SELF_REWRITE_MODE_B(mode_b), .VERIFY_FAULT(vfault),
		.SEQUENCER_READY_FLAG(ready), .PROGRAM_ERROR_FLAG(perr), .ERASE_ERROR_FLAG(eerr),
		.STATUS_READ_MODE(srm));
	flsq_cpu_model cpu_inst (.clk(clk_sys), .mode_b(mode_b), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_addr(bus_addr), .bus_wdata(bus_wdata));
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] ex);
		checked++;
		if (seen !== ex)
		begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, ex, seen);
		end
	endtask
	task automatic give_verdict();
		$display("Counts: %0d checks, %0d errors", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Order: ready, program error, erase error, status read mode
	task automatic flags(input logic r, input logic p, input logic e, input logic s);
		@(negedge clk_sys);
		check("flags", 16'({ready, perr, eerr, srm}), 16'({r, p, e, s}));
	endtask
	task automatic rd_exp(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] ex);
		exp_q.push_back(ex);
		cpu_inst.rd(ad);
	endtask
	task automatic wait_ready(output int busy);
		busy = 0;
		@(negedge clk_sys);
		while (ready !== 1'b1 && busy < 5000)
		begin
			busy++;
			@(negedge clk_sys);
		end
	endtask
	initial
	begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	always @(negedge clk_sys)
		if (rvalid === 1'b1)
			check("read data", {8'h00, rdata}, {8'h00, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX});
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			err_count++;
			give_verdict();
		end
	end
	initial
	begin
		rst = 1'b1;
		{cpu_rew, b01_en, lock0, lock1, mode_b, vfault} = 6'h30;
		ce = 1'b1;
		void'($urandom(22325));
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		flags(1, 0, 0, 0);
		cpu_inst.erase(12'h9A5);
		flags(0, 0, 0, 1);
		rd_exp(12'h800, 8'h00);
		wait_ready(n);
		// The flag check and the status read took two of the busy cycles
		check("erase busy", 16'(n + 2), 16'(ERASE_N));
		flags(1, 0, 0, 1);
		rd_exp(12'h801, 8'h80);
		cpu_inst.wr(12'h000, CMD_READ_ARRAY);
		flags(1, 0, 0, 0);
		rd_exp(12'h800, ERASED_BYTE);
		rd_exp(12'hBFF, ERASED_BYTE);
		// Target is freshly erased, so it is programmed once only
		a = 12'h800 + 12'($urandom % 512);
		d = 8'($urandom % 255);
		cpu_inst.prog(a, d);
		wait_ready(n);
		check("program busy", 16'(n), 16'(1 + PROG_CYCLES));
		rd_exp(a, 8'h80);
		cpu_inst.wr(a, CMD_READ_ARRAY);
		rd_exp(a, d);
		rd_exp(a ^ 12'h001, ERASED_BYTE);
		@(posedge clk_sys);
		vfault <= 1'b1;
		cpu_inst.prog(12'hA10, 8'h3C);
		wait_ready(n);
		flags(1, 1, 0, 1);
		cpu_inst.wr(12'h000, CMD_READ_ARRAY);
		cpu_inst.wr(12'h000, CMD_READ_STATUS);
		rd_exp(12'h123, 8'h90);
		cpu_inst.prog(12'hA20, 8'h11);
		flags(1, 1, 0, 1);
		cpu_inst.wr(12'h000, CMD_CLEAR_STATUS);
		flags(1, 0, 0, 1);
		cpu_inst.erase(12'hA00);
		wait_ready(n);
		flags(1, 0, 1, 1);
		rd_exp(12'h000, 8'hA0);
		@(posedge clk_sys);
		vfault <= 1'b0;
		cpu_inst.wr(12'h000, CMD_CLEAR_STATUS);
		for (int i = 0; i < 5; i++)
		begin
			@(posedge clk_sys);
			{b01_en, lock0, lock1} <= prot_tab[i][14:12];
			if (i % 2)
				cpu_inst.prog(prot_tab[i][11:0], 8'h5A);
			else
				cpu_inst.erase(prot_tab[i][11:0]);
			flags(1, 1, 1, 1);
			cpu_inst.wr(12'h000, CMD_CLEAR_STATUS);
		end
		@(posedge clk_sys);
		{b01_en, lock0, lock1} <= 3'h4;
		cpu_inst.wr(12'h800, CMD_ERASE);
		cpu_inst.wr(12'h800, 8'h77);
		flags(1, 1, 1, 1);
		cpu_inst.wr(12'h000, CMD_CLEAR_STATUS);
		cpu_inst.wr(12'h000, 8'h33);
		flags(1, 1, 1, 1);
		cpu_inst.wr(12'h000, CMD_CLEAR_STATUS);
		foreach (prot_tab[i])
		begin
			if (i < 2)
			begin
				cpu_inst.wr(12'h900, i ? CMD_PROGRAM : CMD_ERASE);
				cpu_inst.wr(12'h900, CMD_READ_ARRAY);
				flags(1, 0, 0, 0);
			end
		end
		@(posedge clk_sys);
		cpu_rew <= 1'b0;
		cpu_inst.wr(12'h000, CMD_READ_STATUS);
		cpu_inst.wr(12'h000, 8'h33);
		flags(1, 0, 0, 0);
		@(posedge clk_sys);
		cpu_rew <= 1'b1;
		ce <= 1'b0;
		// A command strobed while the clock enable is low must be lost
		cpu_inst.wr(12'h000, CMD_READ_STATUS);
		flags(1, 0, 0, 0);
		@(posedge clk_sys);
		ce <= 1'b1;
		mode_b <= 1'b1;
		cpu_inst.prog(12'hB00, 8'h42);
		wait_ready(n);
		flags(1, 0, 0, 0);
		rd_exp(12'hB00, 8'h42);
		repeat (4) @(posedge clk_sys);
		check("pending reads", 16'(exp_q.size()), 16'h0000);
		give_verdict();
	end
endmodule
